// ### common/dcsm_map.svh
// Constants of the device clock synchronisation manager: register offsets,
// field positions, reset values and timing counts.
// Assumes one APB slave with 32-bit data, each register one aligned word.
//
// Overview of operation
// [RULE1] Current epoch is offered as the frame time stamp; a weekly frame is demanded.
// [RULE2] Head-end absolute epoch command redefines the whole clock value.
// [RULE3] Head-end offset command shifts time by signed seconds.
// [RULE4] Drift setting adds signed seconds once every configured number of days.
// [RULE5] Probe starts after download announcement or detected large time error.
// [RULE6] Periodic probe every configured months plus random 0 to 30 days.
// [RULE7] Period zero disables periodic probing; reset period is six months.
// [RULE8] Reply offset is low 16 epoch bits minus reply stamp, signed.
// [RULE9] Fine correction is scheduled only for offsets from -127 to +127.
// [RULE10] Corrections are held pending and applied at 00:00 UTC.
// [RULE11] At midnight pending epoch, offset and drift settings are applied.
// [RULE12] After a correction the next data message carries a done flag.
// [RULE13] A head-end command that day discards the pending fine adjustment.
// [RULE14] Of several head-end commands in a day only the last is kept.
// [RULE15] Gateways answer each probe with a reply carrying their time stamp.
// [RULE16] The radio modem stamps received uplinks with its own clock.
// [RULE17] Fine correction subtracts the signed offset from the epoch modulo 2^32.
`ifndef DCSM_MAP_SVH
`define DCSM_MAP_SVH

`define DCSM_ADDR_EPOCH      12'h000
`define DCSM_ADDR_CMD_VALUE  12'h004
`define DCSM_ADDR_CMD        12'h008
`define DCSM_ADDR_DRIFT      12'h00C
`define DCSM_ADDR_PERIOD     12'h010
`define DCSM_ADDR_STATUS     12'h014
`define DCSM_ADDR_IRQ_STAT   12'h018
`define DCSM_ADDR_IRQ_MASK   12'h01C
`define DCSM_ADDR_PROBE_CTL  12'h020
`define DCSM_ADDR_FINE_OFS   12'h024

`define DCSM_CMD_ABS_BIT     0
`define DCSM_CMD_OFS_BIT     1
`define DCSM_CMD_DRIFT_BIT   2
`define DCSM_DRIFT_SEC_LSB   0
`define DCSM_DRIFT_DAYS_LSB  16

`define DCSM_PERIOD_RESET    8'h06
`define DCSM_LFSR_SEED       16'hACE1
`define DCSM_FINE_LIMIT      16'sd127
`define DCSM_SEC_PER_DAY     17'd86400
`define DCSM_DAYS_PER_MONTH  16'd30
`define DCSM_RAND_DAYS_MAX   5'd30
`define DCSM_WEEK_SECONDS    20'd604800

`define DCSM_IRQ_MIDNIGHT    0
`define DCSM_IRQ_PROBE       1
`define DCSM_IRQ_WEEK        2
`define DCSM_IRQ_FINE_REJ    3
`define DCSM_IRQ_WIDTH       4

`endif

// ### common/dcsm_pkg.sv
// Types of the device clock synchronisation manager.
// Assumes dcsm_map.svh is on the include path.
package dcsm_pkg;
    typedef enum logic [1:0] {
        DCSM_HE_NONE,
        DCSM_HE_ABS,
        DCSM_HE_OFS
    } dcsm_he_kind_t;
endpackage : dcsm_pkg

// ### core/dcsm_apb_slave.sv
// APB slave front end: one-cycle-later answer, registered ready and read data.
// Assumes APB3 master; read data word selected by the core combinationally.
`timescale 1ns/1ps
`default_nettype none
module dcsm_apb_slave
    import dcsm_pkg::*;
(
    input wire logic clk_sys_i,         // System clock
    input wire logic rst_n_i,           // Synchronous reset, active low
    input wire logic psel_i,            // APB select
    input wire logic penable_i,         // APB enable
    input wire logic pwrite_i,          // APB direction
    input wire logic [31:0] rdata_i,    // Read word from core
    input wire logic addr_ok_i,         // Address is mapped
    output logic wr_stb_o,              // One-cycle write strobe
    output logic pready_o,              // APB ready
    output logic pslverr_o,             // APB error
    output logic [31:0] prdata_o        // APB read data
);
    wire access = psel_i && penable_i && !pready_o;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            wr_stb_o <= 1'b0;
        end else begin
            pready_o <= access;
            pslverr_o <= access && !addr_ok_i;
            prdata_o <= (access && !pwrite_i && addr_ok_i) ? rdata_i : 32'h0000_0000;
            wr_stb_o <= access && pwrite_i && addr_ok_i;
        end
    end
endmodule : dcsm_apb_slave
`default_nettype wire

// ### core/dcsm_core.sv
// Device clock synchronisation manager: seconds epoch, pending corrections
// applied at midnight, fine correction from probe replies, periodic probing.
// Assumes a one-second tick pulse in the clk_sys_i domain and an APB master.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dcsm_map.svh"
module dcsm_core
    import dcsm_pkg::*;
#(
    parameter int EPOCH_W = 32
) (
    input wire logic clk_sys_i,             // System clock, 250 MHz
    input wire logic rst_n_i,               // Synchronous reset, active low
    input wire logic sec_tick_i,            // One-second tick pulse
    input wire logic [11:0] paddr_i,        // APB address
    input wire logic psel_i,                // APB select
    input wire logic penable_i,             // APB enable
    input wire logic pwrite_i,              // APB direction
    input wire logic [31:0] pwdata_i,       // APB write data
    output logic [31:0] prdata_o,           // APB read data
    output logic pready_o,                  // APB ready
    output logic pslverr_o,                 // APB error
    input wire logic reply_valid_i,         // Probe reply received pulse
    input wire logic [15:0] reply_stamp_i,  // Gateway stamp of the reply
    input wire logic dl_announce_i,         // Download announcement pulse
    input wire logic time_err_i,            // Application time error pulse
    input wire logic data_sent_i,           // Non-redundant data message sent pulse
    output logic [31:0] frame_time_stamp_field_o, // Epoch for uplink stamp
    output logic corr_done_flag_o,          // Set the done flag in next data message
    output logic probe_start_o,             // Start coverage probe pulse
    output logic irq_o                      // Interrupt, level
);
    logic [EPOCH_W-1:0] epoch;
    logic [16:0] sec_of_day;
    logic [31:0] pend_value;
    dcsm_he_kind_t pend_kind;
    logic [31:0] drift_setting;
    logic [31:0] pend_drift;
    logic pend_drift_v;
    logic [15:0] drift_day_cnt;
    logic [7:0] periodic_probe_months;
    logic [15:0] probe_day_cnt;
    logic [15:0] probe_target;
    logic pend_fine_v;
    logic signed [15:0] pend_fine;
    logic signed [15:0] last_fine;
    logic [19:0] week_cnt;
    logic [`DCSM_IRQ_WIDTH-1:0] irq_stat;
    logic [`DCSM_IRQ_WIDTH-1:0] irq_mask;
    logic [31:0] rd_word;
    logic addr_ok;
    logic wr_stb;
    logic [4:0] rand_days;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;

    // Fine offset: low 16 epoch bits minus reply stamp, as signed
    wire signed [15:0] fine_ofs = $signed(epoch[15:0] - reply_stamp_i); // RULE8
    wire fine_ok = (fine_ofs <= `DCSM_FINE_LIMIT) && (fine_ofs >= -`DCSM_FINE_LIMIT); // RULE9
    wire midnight = sec_tick_i && (sec_of_day == `DCSM_SEC_PER_DAY - 17'd1);
    wire he_cmd_wr = wr_stb && (wr_addr == `DCSM_ADDR_CMD);
    wire he_any = pend_kind != DCSM_HE_NONE || pend_drift_v;
    wire signed [15:0] drift_sec = $signed(drift_setting[15:0]);
    wire [15:0] drift_days = drift_setting[31:16];
    wire drift_due = (drift_days != 16'h0000) && (drift_day_cnt + 16'd1 >= drift_days);
    // Drift step rides along with an offset or fine correction on its day, not with an absolute epoch
    wire [31:0] drift_add = drift_due ? {{16{drift_sec[15]}}, drift_sec} : 32'h0000_0000;
    wire probe_due = (periodic_probe_months != 8'h00) && (probe_day_cnt + 16'd1 >= probe_target);
    wire week_due = sec_tick_i && (week_cnt == `DCSM_WEEK_SECONDS - 20'd1);
    wire probe_ev = dl_announce_i || time_err_i || (midnight && probe_due);
    wire [`DCSM_IRQ_WIDTH-1:0] irq_ev = {reply_valid_i && !fine_ok, week_due,
                                         probe_ev, midnight && (he_any || pend_fine_v)};

    dcsm_apb_slave u_apb (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .rdata_i(rd_word),
        .addr_ok_i(addr_ok),
        .wr_stb_o(wr_stb),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .prdata_o(prdata_o)
    );

    dcsm_lfsr u_lfsr (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .rand_days_o(rand_days)
    );

    // Address and data held for the strobe one cycle after the access
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wr_addr <= 12'h000;
            wr_data <= 32'h0000_0000;
        end else begin
            wr_addr <= paddr_i;
            wr_data <= pwdata_i;
        end
    end

    always_comb begin
        addr_ok = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr_i)
            `DCSM_ADDR_EPOCH: rd_word = epoch;
            `DCSM_ADDR_CMD_VALUE: rd_word = pend_value;
            `DCSM_ADDR_CMD: rd_word = {29'h0, pend_drift_v, pend_kind == DCSM_HE_OFS,
                                       pend_kind == DCSM_HE_ABS};
            `DCSM_ADDR_DRIFT: rd_word = drift_setting;
            `DCSM_ADDR_PERIOD: rd_word = {24'h0, periodic_probe_months};
            `DCSM_ADDR_STATUS: rd_word = {15'h0, sec_of_day};
            `DCSM_ADDR_IRQ_STAT: rd_word = {28'h0, irq_stat};
            `DCSM_ADDR_IRQ_MASK: rd_word = {28'h0, irq_mask};
            `DCSM_ADDR_PROBE_CTL: rd_word = {16'h0, probe_target};
            `DCSM_ADDR_FINE_OFS: rd_word = {15'h0, pend_fine_v, last_fine};
            default: addr_ok = 1'b0;
        endcase
    end

    // Epoch: tick, then midnight corrections add to the increment; an absolute epoch replaces it
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            epoch <= '0;
        end else if (midnight && pend_kind == DCSM_HE_ABS) begin
            epoch <= pend_value; // RULE2 RULE11
        end else if (midnight && pend_kind == DCSM_HE_OFS) begin
            epoch <= epoch + 32'd1 + pend_value + drift_add; // RULE3 RULE11
        end else if (midnight && pend_fine_v && !he_any) begin
            epoch <= epoch + 32'd1 + drift_add
                     - {{16{pend_fine[15]}}, pend_fine}; // RULE17 RULE13
        end else if (midnight && drift_due) begin
            epoch <= epoch + 32'd1 + {{16{drift_sec[15]}}, drift_sec}; // RULE4
        end else if (sec_tick_i) begin
            epoch <= epoch + 32'd1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sec_of_day <= 17'd0;
        end else if (midnight) begin
            sec_of_day <= 17'd0;
        end else if (sec_tick_i) begin
            sec_of_day <= sec_of_day + 17'd1;
        end
    end

    // Head-end command: newest write replaces the pending one
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pend_kind <= DCSM_HE_NONE;
            pend_value <= 32'h0000_0000;
        end else if (he_cmd_wr && wr_data[`DCSM_CMD_ABS_BIT]) begin
            pend_kind <= DCSM_HE_ABS; // RULE14 RULE10
        end else if (he_cmd_wr && wr_data[`DCSM_CMD_OFS_BIT]) begin
            pend_kind <= DCSM_HE_OFS; // RULE14 RULE10
        end else if (he_cmd_wr && wr_data[`DCSM_CMD_DRIFT_BIT]) begin
            pend_kind <= DCSM_HE_NONE; // RULE14
        end else if (midnight) begin
            pend_kind <= DCSM_HE_NONE;
        end
        if (rst_n_i && wr_stb && wr_addr == `DCSM_ADDR_CMD_VALUE) begin
            pend_value <= wr_data;
        end
    end

    // Drift setting staged and taken over at midnight
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pend_drift <= 32'h0000_0000;
            pend_drift_v <= 1'b0;
            drift_setting <= 32'h0000_0000;
        end else if (wr_stb && wr_addr == `DCSM_ADDR_DRIFT) begin
            pend_drift <= wr_data;
        end else if (he_cmd_wr) begin
            pend_drift_v <= wr_data[`DCSM_CMD_DRIFT_BIT]; // RULE14
        end else if (midnight && pend_drift_v) begin
            drift_setting <= pend_drift; // RULE11
            pend_drift_v <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            drift_day_cnt <= 16'h0000;
        end else if (midnight) begin
            drift_day_cnt <= drift_due ? 16'h0000 : drift_day_cnt + 16'd1; // RULE4
        end
    end

    // Fine correction held until midnight, dropped if the head-end spoke
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pend_fine_v <= 1'b0;
            pend_fine <= 16'sh0000;
            last_fine <= 16'sh0000;
        end else if (midnight) begin
            pend_fine_v <= 1'b0; // RULE13
        end else if (reply_valid_i) begin
            last_fine <= fine_ofs; // RULE8
            if (fine_ok) begin
                pend_fine_v <= 1'b1; // RULE9 RULE10
                pend_fine <= fine_ofs;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            periodic_probe_months <= `DCSM_PERIOD_RESET; // RULE7
        end else if (wr_stb && wr_addr == `DCSM_ADDR_PERIOD) begin
            periodic_probe_months <= wr_data[7:0];
        end
    end

    // Periodic probe: months times thirty days plus random spread
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            probe_day_cnt <= 16'h0000;
            probe_target <= 16'h0000;
        end else if (periodic_probe_months == 8'h00) begin
            probe_day_cnt <= 16'h0000; // RULE7
        end else if (probe_target == 16'h0000 || (midnight && probe_due)) begin
            probe_day_cnt <= 16'h0000;
            probe_target <= 16'(periodic_probe_months * `DCSM_DAYS_PER_MONTH)
                            + {11'h0, rand_days}; // RULE6
        end else if (midnight) begin
            probe_day_cnt <= probe_day_cnt + 16'd1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            probe_start_o <= 1'b0;
        end else begin
            probe_start_o <= probe_ev; // RULE5 RULE6
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            frame_time_stamp_field_o <= 32'h0000_0000;
        end else begin
            frame_time_stamp_field_o <= epoch; // RULE1
        end
    end

    // Weekly watchdog: every stamped data message restarts it
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            week_cnt <= 20'h0_0000;
        end else if (data_sent_i || week_due) begin
            week_cnt <= 20'h0_0000; // RULE1
        end else if (sec_tick_i) begin
            week_cnt <= week_cnt + 20'd1;
        end
    end

    // Done flag: the set wins over the clear by a sent message
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            corr_done_flag_o <= 1'b0;
        end else if (midnight && (he_any || pend_fine_v || drift_due)) begin
            corr_done_flag_o <= 1'b1; // RULE12
        end else if (data_sent_i) begin
            corr_done_flag_o <= 1'b0; // RULE12
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            irq_stat <= '0;
        end else if (wr_stb && wr_addr == `DCSM_ADDR_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~wr_data[`DCSM_IRQ_WIDTH-1:0]) | irq_ev;
        end else begin
            irq_stat <= irq_stat | irq_ev;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            irq_mask <= '0;
        end else if (wr_stb && wr_addr == `DCSM_ADDR_IRQ_MASK) begin
            irq_mask <= wr_data[`DCSM_IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
        end
    end
endmodule : dcsm_core
`default_nettype wire

// ### core/dcsm_lfsr.sv
// Free-running pseudo-random day generator for the periodic probe spread.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "dcsm_map.svh"
module dcsm_lfsr
    import dcsm_pkg::*;
(
    input wire logic clk_sys_i,         // System clock
    input wire logic rst_n_i,           // Synchronous reset, active low
    output logic [4:0] rand_days_o      // Random days 0 to 30
);
    logic [15:0] lfsr;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            lfsr <= `DCSM_LFSR_SEED;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end

    // Fold 31 onto 30 so the range stays 0..30
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rand_days_o <= 5'h0;
        end else if (lfsr[4:0] > `DCSM_RAND_DAYS_MAX) begin
            rand_days_o <= `DCSM_RAND_DAYS_MAX;
        end else begin
            rand_days_o <= lfsr[4:0];
        end
    end
endmodule : dcsm_lfsr
`default_nettype wire

// ### tb/dcsm_core_checker.sv
// Port checker of dcsm_core: APB answer, probe start, stamp, done flag.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dcsm_core_checker (
    input wire logic clk_sys_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic sec_tick_i, // Seconds tick
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pready_o, // APB ready
    input wire logic pslverr_o, // APB error
    input wire logic dl_announce_i, // Download announcement
    input wire logic time_err_i, // Time error seen
    input wire logic data_sent_i, // Data message sent
    input wire logic [31:0] frame_time_stamp_field_o, // Uplink stamp
    input wire logic corr_done_flag_o, // Done flag
    input wire logic probe_start_o // Probe start
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_probe_go;
        dl_announce_i || time_err_i |=> probe_start_o;
    endproperty
    a_probe_go: assert property (p_probe_go) else $error("probe start missing");
    property p_probe_why;
        probe_start_o |-> $past(dl_announce_i) || $past(time_err_i) || $past(sec_tick_i)
            || $past(sec_tick_i, 2);
    endproperty
    a_probe_why: assert property (p_probe_why) else $error("probe without cause");
    property p_stamp_still;
        !sec_tick_i [*2] |=> $stable(frame_time_stamp_field_o);
    endproperty
    a_stamp_still: assert property (p_stamp_still) else $error("stamp moved");
    property p_done_cause;
        $rose(corr_done_flag_o) |-> $past(sec_tick_i) || $past(sec_tick_i, 2);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("flag off midnight");
    property p_done_hold;
        corr_done_flag_o && !data_sent_i |=> corr_done_flag_o;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("flag lost");
    property p_done_clear;
        !sec_tick_i ##1 (data_sent_i && !sec_tick_i) |=> !corr_done_flag_o;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("flag not cleared");
    property p_apb_answer;
        psel_i && penable_i && !pready_o |-> ##1 pready_o;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("late ready");
    property p_apb_once;
        pready_o |=> !pready_o;
    endproperty
    a_apb_once: assert property (p_apb_once) else $error("ready too long");
    property p_apb_err;
        pslverr_o |-> pready_o;
    endproperty
    a_apb_err: assert property (p_apb_err) else $error("error without ready");
    c_probe: cover property (probe_start_o);
    c_done: cover property ($rose(corr_done_flag_o));
    c_err: cover property (pslverr_o);
endmodule : dcsm_core_checker
bind dcsm_core dcsm_core_checker dcsm_core_checker_i (.clk_sys_i, .rst_n_i, .sec_tick_i,
    .psel_i, .penable_i, .pready_o, .pslverr_o, .dl_announce_i, .time_err_i, .data_sent_i,
    .frame_time_stamp_field_o, .corr_done_flag_o, .probe_start_o);
`default_nettype wire

// ### tb/dcsm_gw_model.sv
// Gateway model: answers a coverage probe with its own seconds stamp; a new probe before the answer restarts the lag.
// Assumes probe_i is a one-cycle pulse from the device.
`timescale 1ns/1ps
`default_nettype none
module dcsm_gw_model (
    input wire logic clk_sys_i, // Clock
    input wire logic probe_i, // Probe sent by device
    input wire logic [15:0] gw_time_i, // Gateway clock, seconds
    input wire logic [3:0] lag_i, // Answer delay in cycles
    input wire logic uplink_i, // Uplink frame received
    input wire logic [31:0] frame_stamp_i, // Device stamp carried by the frame
    output logic reply_valid_o, // Reply pulse
    output logic [15:0] reply_stamp_o, // Reply stamp
    output logic [31:0] rx_frame_stamp_o, // Stamp of the last uplink
    output logic [15:0] rx_time_o // Gateway clock at that uplink
);
    int cnt = -1;
    initial begin
        reply_valid_o = 1'b0;
        reply_stamp_o = 16'h0000;
        rx_frame_stamp_o = 32'h0000_0000;
        rx_time_o = 16'h0000;
    end
    always @(posedge clk_sys_i) begin
        reply_valid_o <= 1'b0;
        if (uplink_i) begin
            rx_frame_stamp_o <= frame_stamp_i;
            rx_time_o <= gw_time_i;
        end
        reply_stamp_o <= ~reply_stamp_o; // Meaningless outside a reply
        if (probe_i) begin
            cnt <= lag_i;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0) begin
            cnt <= -1;
            reply_valid_o <= 1'b1;
            reply_stamp_o <= gw_time_i;
        end
    end
endmodule : dcsm_gw_model
`default_nettype wire

// ### tb/test_device_clock_sync_manager.sv
// Self-checking bench of dcsm_core with a gateway model answering probes.
// Assumes ticks on consecutive cycles are accepted, so midnight comes early.
`timescale 1ns/1ps
`default_nettype none
`include "dcsm_map.svh"
module test_device_clock_sync_manager import dcsm_pkg::*;;
    logic clk_sys_i, rst_n_i, sec_tick_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic dl_announce_i, time_err_i, data_sent_i, reply_valid_i, corr_done_flag_o;
    logic probe_start_o, irq_o, err;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, frame_time_stamp_field_o, rd, epoch_m, ofs, rx_stamp;
    logic [15:0] reply_stamp_i, gw_time, seed, rx_time;
    logic signed [15:0] d;
    logic [3:0] lag;
    int err_total, n_tests, ticks;
    dcsm_core dcsm_core_i (.clk_sys_i, .rst_n_i, .sec_tick_i, .paddr_i, .psel_i, .penable_i,
        .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .reply_valid_i,
        .reply_stamp_i, .dl_announce_i, .time_err_i, .data_sent_i,
        .frame_time_stamp_field_o, .corr_done_flag_o, .probe_start_o, .irq_o);
    dcsm_gw_model dcsm_gw_model_i (.clk_sys_i, .probe_i(probe_start_o), .gw_time_i(gw_time),
        .lag_i(lag), .uplink_i(data_sent_i), .frame_stamp_i(frame_time_stamp_field_o),
        .reply_valid_o(reply_valid_i), .reply_stamp_o(reply_stamp_i),
        .rx_frame_stamp_o(rx_stamp), .rx_time_o(rx_time));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            err_total++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
        int k;
        k = 0;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= v;
        cyc(1);
        penable_i <= 1'b1;
        do begin
            cyc(1);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_total++;
            wrap_up();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        cyc(1);
    endtask : apb
    task automatic tick(input int n, input logic [31:0] adj);
        sec_tick_i <= 1'b1;
        cyc(n);
        sec_tick_i <= 1'b0;
        epoch_m = epoch_m + 32'(n) + adj;
        ticks += n;
        cyc(3);
        check(frame_time_stamp_field_o, epoch_m);
    endtask : tick
    task automatic probe(input logic ann, input logic [15:0] stamp);
        gw_time <= stamp;
        dl_announce_i <= ann;
        time_err_i <= !ann;
        cyc(1);
        dl_announce_i <= 1'b0;
        time_err_i <= 1'b0;
        cyc(1);
        check(probe_start_o, 1'b1);
        cyc(30);
    endtask : probe
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        {rst_n_i, sec_tick_i, psel_i, penable_i, pwrite_i} = '0;
        {dl_announce_i, time_err_i, data_sent_i} = '0;
        paddr_i = '0;
        pwdata_i = '0;
        gw_time = '0;
        lag = 4'd9;
        seed = 16'd51;
        epoch_m = '0;
        {err_total, n_tests, ticks} = '0;
        cyc(8);
        rst_n_i <= 1'b1;
        cyc(1);
        check(frame_time_stamp_field_o, epoch_m);
        apb(0, `DCSM_ADDR_PERIOD, '0);
        check(rd, 32'(`DCSM_PERIOD_RESET));
        apb(0, `DCSM_ADDR_PROBE_CTL, '0);
        check(rd >= `DCSM_PERIOD_RESET * `DCSM_DAYS_PER_MONTH
            && rd <= `DCSM_PERIOD_RESET * `DCSM_DAYS_PER_MONTH + `DCSM_RAND_DAYS_MAX, 1'b1);
        apb(0, 12'h028, '0);
        check(err, 1'b1);
        $display("reset and map test done");
        apb(1, `DCSM_ADDR_IRQ_MASK, 32'h0000_0002);
        tick(100, '0);
        probe(1'b1, epoch_m[15:0] - 16'd200);
        apb(0, `DCSM_ADDR_IRQ_STAT, '0);
        check(rd, 32'h0000_000A);
        check(irq_o, 1'b1);
        apb(1, `DCSM_ADDR_IRQ_STAT, 32'h0000_000A);
        cyc(2);
        check(irq_o, 1'b0);
        seed = lfsr(seed);
        d = 16'(seed[6:0]);
        if (seed[7]) d = -d;
        lag = 4'd0;
        probe(1'b0, epoch_m[15:0] - d);
        apb(0, `DCSM_ADDR_FINE_OFS, '0);
        check(rd, {15'h0000, 1'b1, d});
        $display("probe test done");
        seed = lfsr(seed);
        apb(1, `DCSM_ADDR_CMD_VALUE, {seed, seed});
        apb(1, `DCSM_ADDR_CMD, 32'h0000_0001);
        apb(0, `DCSM_ADDR_CMD, '0);
        check(rd, 32'h0000_0001);
        seed = lfsr(seed);
        ofs = {{20{seed[11]}}, seed[11:0]};
        apb(1, `DCSM_ADDR_CMD_VALUE, ofs);
        apb(1, `DCSM_ADDR_DRIFT, 32'h0007_0003);
        apb(1, `DCSM_ADDR_CMD, 32'h0000_0006);
        apb(0, `DCSM_ADDR_CMD, '0);
        check(rd, 32'h0000_0006);
        tick(86399 - ticks, '0);
        check(corr_done_flag_o, 1'b0);
        tick(1, ofs);
        check(corr_done_flag_o, 1'b1);
        apb(0, `DCSM_ADDR_DRIFT, '0);
        check(rd, 32'h0007_0003);
        apb(0, `DCSM_ADDR_CMD, '0);
        check(rd, '0);
        apb(0, `DCSM_ADDR_IRQ_STAT, '0);
        check(rd, 32'h0000_0003);
        data_sent_i <= 1'b1;
        cyc(1);
        data_sent_i <= 1'b0;
        cyc(2);
        check(corr_done_flag_o, 1'b0);
        check(rx_stamp, epoch_m);
        check(rx_time, gw_time);
        apb(1, `DCSM_ADDR_PERIOD, '0);
        apb(0, `DCSM_ADDR_PERIOD, '0);
        check(rd, '0);
        $display("midnight test done");
        wrap_up();
    end
endmodule : test_device_clock_sync_manager
`default_nettype wire
